// *** ber_mon_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bundle between the configuration top and the error rate monitor
interface ber_mon_if;
	logic enable;   // Monitor enabled from the config register
	logic sh_valid; // A block was received this cycle
	logic sh_error; // Its sync header was invalid
	logic hi_ber;   // High error rate condition
	modport top (output enable, output sh_valid, output sh_error,
		input hi_ber);
	modport mon (input enable, input sh_valid, input sh_error,
		output hi_ber);
endinterface : ber_mon_if
`default_nettype wire

// *** ber_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ber_monitor
	import rx_lane_cfg_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	ber_mon_if.mon    bus
);
	// ************************************************************
	// State
	// ************************************************************
	ber_state_e         state;       // Current error rate state
	ber_state_e         next_state;
	logic [TIMER_W-1:0] timer;       // Window cycle counter
	logic [TIMER_W-1:0] next_timer;
	logic [7:0]         err_cnt;     // Errors seen in this window
	logic [7:0]         next_err_cnt;
	logic               win_end;     // Last cycle of the window

	assign win_end = (timer == TIMER_W'(BER_WINDOW_CYCLES - 1));

	// Next-value logic for window, count and state
	always_comb begin
		next_state   = state;
		next_timer   = timer;
		next_err_cnt = err_cnt;
		if (!bus.enable) begin
			// Disabled: hold everything idle, flag cannot rise
			next_state   = BER_OK;
			next_timer   = '0;
			next_err_cnt = '0;
		end else begin
			// Count invalid sync headers in the window
			if (bus.sh_valid && bus.sh_error && err_cnt != BER_THRESHOLD)
				next_err_cnt = err_cnt + 8'h01;
			if (next_err_cnt == BER_THRESHOLD)
				next_state = BER_HIGH; // Threshold reached
			if (win_end) begin
				// Window closes; a quiet window clears the flag
				if (next_err_cnt != BER_THRESHOLD)
					next_state = BER_OK;
				next_timer   = '0;
				next_err_cnt = '0;
			end else begin
				next_timer = timer + TIMER_W'(1);
			end
		end
	end

	// Register stage only
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state   <= BER_OK;
			timer   <= '0;
			err_cnt <= '0;
		end else begin
			state   <= next_state;
			timer   <= next_timer;
			err_cnt <= next_err_cnt;
		end
	end

	// Flag comes straight from the state flop
	assign bus.hi_ber = (state == BER_HIGH);

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	disabled_no_flag_a: assert property (
		!bus.enable |=> !bus.hi_ber)
		else $error("flag raised while monitor disabled");
	threshold_sets_a: assert property (
		bus.enable && bus.sh_valid && bus.sh_error
		&& err_cnt == BER_THRESHOLD - 8'h01 |=> bus.hi_ber)
		else $error("flag not set at error threshold");
	window_len_a: assert property (
		bus.enable && timer == '0 ##1 bus.enable [*8]
		|-> timer == TIMER_W'(8))
		else $error("window timer does not advance");
	quiet_clear_a: assert property (
		bus.enable && win_end && err_cnt < BER_THRESHOLD - 8'h01
		|=> !bus.hi_ber)
		else $error("flag not cleared after quiet window");
	flag_cause_a: assert property (
		$rose(bus.hi_ber) |-> $past(bus.sh_error) && $past(bus.enable))
		else $error("flag rose without a header error");
	cover_high_c: cover property ($rose(bus.hi_ber));
	cover_clear_c: cover property ($fell(bus.hi_ber) && bus.enable);
endmodule : ber_monitor
`default_nettype wire

// *** link_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Far end of the link: block stream and skew reports
// ****
module link_partner_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	output var  logic       o_block_valid,
	output var  logic       o_sync_header_error,
	output var  logic       o_skew_valid,
	output var  logic [5:0] o_lane_skew
);
	// Quiet until reset is gone, then one block every cycle
	initial begin
		o_block_valid = 1'b0;
		o_sync_header_error = 1'b0;
		o_skew_valid = 1'b0;
		o_lane_skew = 6'h00;
		@(posedge i_rst_n);
		@(posedge i_ref_clk) #1;
		o_block_valid = 1'b1;
	end
	// Back to back bad sync headers, one per block
	task automatic send_errors(input int n);
		repeat (n) begin
			@(posedge i_ref_clk) #1;
			o_sync_header_error = 1'b1;
		end
		@(posedge i_ref_clk) #1;
		o_sync_header_error = 1'b0;
	endtask : send_errors
	// Bad headers on empty cycles, which must not be counted
	task automatic send_gaps(input int n);
		@(posedge i_ref_clk) #1;
		o_block_valid = 1'b0;
		o_sync_header_error = 1'b1;
		repeat (n) @(posedge i_ref_clk);
		#1 o_block_valid = 1'b1;
		o_sync_header_error = 1'b0;
	endtask : send_gaps
	// One report; skew shows its inverse once out of hold time
	task automatic send_skew(input logic [5:0] v);
		@(posedge i_ref_clk) #1;
		o_skew_valid = 1'b1;
		o_lane_skew = v;
		@(posedge i_ref_clk) #1;
		o_skew_valid = 1'b0;
		o_lane_skew = ~v;
	endtask : send_skew
endmodule : link_partner_model
`default_nettype wire

// *** rx_lane_cfg_pkg.sv ***
`default_nettype none
package rx_lane_cfg_pkg;
	// ************************************************************
	// Register map (word addresses, no byte addressing)
	// ************************************************************
	localparam logic [15:0] RX_LANE_CONFIG_ADDR = 16'h0360; // Config word
	localparam int          MON_EN_BIT          = 20;       // Monitor enable
	localparam int          SKEW_LSB            = 14;       // Skew limit low
	localparam int          SKEW_W              = 6;        // Skew limit width
	localparam int          STAT_BER_BIT        = 31;       // Flag readback
	localparam int          STAT_ALIGN_BIT      = 30;       // Align readback
	localparam logic [5:0]  SKEW_MIN            = 6'h01;    // Lowest limit
	localparam logic [5:0]  SKEW_RESET          = 6'h2f;    // 47 decimal
	localparam logic        MON_EN_RESET        = 1'b1;     // Monitor on

	// ************************************************************
	// Error rate window timing
	// ************************************************************
	localparam int          REF_CLK_PERIOD_NS   = 40;       // 25 MHz
	localparam int          BER_WINDOW_NS       = 125000;   // 125 us window
	localparam int          BER_WINDOW_CYCLES   =
		BER_WINDOW_NS / REF_CLK_PERIOD_NS;
	localparam int          TIMER_W             = 12;       // Holds 3125
	localparam logic [7:0]  BER_THRESHOLD       = 8'h61;    // 97 errors

	// Error rate state
	typedef enum logic {BER_OK, BER_HIGH} ber_state_e;
endpackage : rx_lane_cfg_pkg
`default_nettype wire

// *** rx_pcs_ber_skew_config.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Enabled monitor counts header errors per window
// - High error condition drives flag to one
// - Disabled monitor never raises the flag
// - Enable bit 20 resets to parameter value
// - Skew limit settable 1 to 47
// - Bits 19:14 reset to skew parameter
// - Whole 32-bit word accesses, word addresses
module rx_pcs_ber_skew_config
	import rx_lane_cfg_pkg::*;
#(
	parameter logic       ERROR_RATE_MONITOR_PARAM = MON_EN_RESET, // On/off
	parameter logic [5:0] LANE_SKEW_LIMIT_PARAM    = SKEW_RESET    // 1..47
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	input  wire logic [15:0] i_reconfig_addr,
	input  wire logic        i_reconfig_read,
	input  wire logic        i_reconfig_write,
	input  wire logic [31:0] i_reconfig_writedata,
	output logic      [31:0] o_reconfig_readdata,
	output logic             o_reconfig_readdatavalid,
	output logic             o_reconfig_waitrequest,
	input  wire logic        i_block_valid,
	input  wire logic        i_sync_header_error,
	input  wire logic        i_skew_valid,
	input  wire logic [5:0]  i_lane_skew,
	output logic             o_high_error_rate_flag,
	output logic             o_align_fail,
	output logic             o_deskew_retry
);
	// ************************************************************
	// Reset release
	// ************************************************************
	// Two stages so every flop leaves reset on the same edge
	logic rst_meta; // First stage, read only by rst_n
	logic rst_n;    // Synchronised reset used everywhere else

	// Assert at once, release after two edges
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// Pin low: both stages clear at once
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			// Shift the released level through both stages
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ************************************************************
	// Configuration register
	// ************************************************************
	logic        mon_enable;      // Monitor enable field
	logic        next_mon_enable;
	logic [5:0]  skew_limit;      // Lane skew limit field
	logic [5:0]  next_skew_limit;
	logic [31:0] rdata;           // Registered read data
	logic [31:0] next_rdata;
	logic        rvalid;          // Read answer strobe
	logic        next_rvalid;
	logic        hit;             // Address matches the config word
	logic [5:0]  wr_skew;         // Skew field of the write word

	assign hit     = (i_reconfig_addr == RX_LANE_CONFIG_ADDR);
	assign wr_skew = i_reconfig_writedata[SKEW_LSB +: SKEW_W];

	// Register writes and read answers
	always_comb begin
		// Fields hold unless written; read data idles at zero
		next_mon_enable = mon_enable;
		next_skew_limit = skew_limit;
		next_rdata      = '0;
		next_rvalid     = 1'b0;
		if (i_reconfig_write && hit) begin
			// Whole word written; only defined fields store
			next_mon_enable = i_reconfig_writedata[MON_EN_BIT];
			// Out of range limits are ignored to keep 1..47
			if (wr_skew >= SKEW_MIN && wr_skew <= SKEW_RESET)
				next_skew_limit = wr_skew;
		end
		if (i_reconfig_read) begin
			// Unmapped words answer with zero
			next_rvalid = 1'b1;
			if (hit) begin
				// Status bits are read-only; writes cannot reach them
				next_rdata[MON_EN_BIT]              = mon_enable;
				next_rdata[SKEW_LSB +: SKEW_W]      = skew_limit;
				next_rdata[STAT_BER_BIT]            = o_high_error_rate_flag;
				next_rdata[STAT_ALIGN_BIT]          = o_align_fail;
			end
		end
	end

	// Field reset values come from the build parameters; read answer resets to zero
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_enable <= ERROR_RATE_MONITOR_PARAM;
			skew_limit <= LANE_SKEW_LIMIT_PARAM;
			rdata      <= '0;
			rvalid     <= 1'b0;
		end else begin
			// Take the computed values
			mon_enable <= next_mon_enable;
			skew_limit <= next_skew_limit;
			rdata      <= next_rdata;
			rvalid     <= next_rvalid;
		end
	end

	// Port never stalls, so the requester needs no wait handling
	assign o_reconfig_waitrequest   = 1'b0;
	assign o_reconfig_readdata      = rdata;
	assign o_reconfig_readdatavalid = rvalid;

	// ************************************************************
	// Error rate monitor
	// ************************************************************
	ber_mon_if mon_bus ();

	// Header inputs come from PCS logic on this clock, no synchroniser
	assign mon_bus.enable   = mon_enable;
	assign mon_bus.sh_valid = i_block_valid;
	assign mon_bus.sh_error = i_sync_header_error;

	// Window, count and state live in the monitor module
	ber_monitor u_ber_monitor (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n),
		.bus       (mon_bus.mon)
	);

	assign o_high_error_rate_flag = mon_bus.hi_ber;

	// ************************************************************
	// Deskew limit check
	// ************************************************************
	logic fail;       // Latest alignment verdict
	logic next_fail;
	logic retry;      // One-cycle retry pulse
	logic next_retry;

	// A measurement above the limit fails and requests a new deskew
	always_comb begin
		// Without a report the verdict holds and no pulse goes out
		next_fail  = fail;
		next_retry = 1'b0;
		if (i_skew_valid) begin
			// Equal skew passes; only a larger one fails
			next_fail  = (i_lane_skew > skew_limit);
			next_retry = next_fail;
		end
	end

	// Register stage only
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fail  <= 1'b0;
			retry <= 1'b0;
		end else begin
			fail  <= next_fail;
			retry <= next_retry;
		end
	end

	// Outputs come straight from the flops
	assign o_align_fail   = fail;
	assign o_deskew_retry = retry;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!rst_n);

	reset_enable_a: assert property (
		$rose(rst_n) |-> mon_enable == ERROR_RATE_MONITOR_PARAM)
		else $error("enable field wrong after reset");
	reset_skew_a: assert property (
		$rose(rst_n) |-> skew_limit == LANE_SKEW_LIMIT_PARAM)
		else $error("skew limit wrong after reset");
	skew_range_a: assert property (
		skew_limit >= SKEW_MIN && skew_limit <= SKEW_RESET)
		else $error("skew limit outside 1..47");
	read_back_a: assert property (
		i_reconfig_read && hit && !i_reconfig_write |=>
		o_reconfig_readdatavalid
		&& o_reconfig_readdata[SKEW_LSB +: SKEW_W] == $past(skew_limit)
		&& o_reconfig_readdata[MON_EN_BIT] == $past(mon_enable))
		else $error("config read returns wrong fields");
	write_enable_a: assert property (
		i_reconfig_write && hit |=>
		mon_enable == $past(i_reconfig_writedata[MON_EN_BIT]))
		else $error("enable field not written");
	// A second failing report may renew the pulse one cycle later
	skew_fail_a: assert property (
		i_skew_valid && i_lane_skew > skew_limit |=>
		o_align_fail && o_deskew_retry
		##1 (!o_deskew_retry || $past(i_skew_valid)))
		else $error("excess skew not flagged");
	skew_pass_a: assert property (
		i_skew_valid && i_lane_skew <= skew_limit |=>
		!o_align_fail && !o_deskew_retry)
		else $error("legal skew flagged as failure");
	cover_retry_c: cover property (o_deskew_retry);
	cover_write_c: cover property (i_reconfig_write && hit);
	cover_keep_c: cover property (i_reconfig_write && hit
		&& wr_skew > SKEW_RESET);
	// Out of range limits must leave the stored limit alone
	skew_keep_a: assert property (
		i_reconfig_write && hit
		&& (wr_skew < SKEW_MIN || wr_skew > SKEW_RESET)
		|=> skew_limit == $past(skew_limit))
		else $error("out of range skew limit stored");
	// Read data is zero outside the answer cycle
	read_idle_a: assert property (
		!i_reconfig_read |=>
		!o_reconfig_readdatavalid && o_reconfig_readdata == '0)
		else $error("read answer without a read");
	no_stall_a: assert property (
		!o_reconfig_waitrequest)
		else $error("register port stalled");
endmodule : rx_pcs_ber_skew_config
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rx_lane_cfg_pkg::*;
	// ****
	// Signals
	// ****
	localparam logic [15:0] BAD_ADDR = 16'h0361; // Unmapped word
	localparam logic [31:0] FLAG_B = 32'h80000000; // Flag readback
	localparam logic [31:0] ALIGN_B = 32'h40000000; // Align readback
	logic clk, rst_n, rd, wr, bv, she, sv, rdv, wrq, flag, afail, retry;
	logic [15:0] addr;
	logic [31:0] wdata, rdata;
	logic [5:0] skew;
	int err_count, checks;
	// ****
	// Design and far end
	// ****
	rx_pcs_ber_skew_config i_rx_pcs_ber_skew_config (.i_ref_clk(clk),
		.i_reset_n(rst_n), .i_reconfig_addr(addr), .i_reconfig_read(rd),
		.i_reconfig_write(wr), .i_reconfig_writedata(wdata),
		.o_reconfig_readdata(rdata), .o_reconfig_readdatavalid(rdv),
		.o_reconfig_waitrequest(wrq), .i_block_valid(bv),
		.i_sync_header_error(she), .i_skew_valid(sv), .i_lane_skew(skew),
		.o_high_error_rate_flag(flag), .o_align_fail(afail),
		.o_deskew_retry(retry));
	link_partner_model i_link_partner_model (.i_ref_clk(clk),
		.i_rst_n(rst_n), .o_block_valid(bv), .o_sync_header_error(she),
		.o_skew_valid(sv), .o_lane_skew(skew));
	// ****
	// Helpers
	// ****
	// Config word image with status bits clear
	function automatic logic [31:0] cfg(input logic e, input logic [5:0] l);
		return {11'h000, e, l, 14'h0000};
	endfunction : cfg
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : check
	// Read answer stands for the single cycle after the request
	task automatic reg_read(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk) #1;
		addr = a;
		rd = 1'b1;
		@(posedge clk) #1;
		rd = 1'b0;
		check(32'(rdv), 32'h1, "read valid");
		check(rdata, exp, "read data");
	endtask : reg_read
	task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk) #1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk) #1;
		wr = 1'b0;
	endtask : reg_write
	// Retry must be a single cycle pulse
	task automatic skew_chk(input logic [5:0] v, input logic f);
		i_link_partner_model.send_skew(v);
		check(32'(afail), 32'(f), "align fail");
		check(32'(retry), 32'(f), "retry pulse");
		@(posedge clk) #1;
		check(32'(retry), 32'h0, "retry width");
	endtask : skew_chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// ****
	// Clock, watchdog, tests
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Longest test waits about 6250 cycles; allow well over double
	initial begin
		#1000000;
		err_count++;
		$display("FAIL %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		{rst_n, rd, wr, addr, wdata} = '0;
		err_count = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		// Reset image, unmapped place, never stalls
		check(32'(wrq), 32'h0, "waitrequest");
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h2f));
		reg_write(BAD_ADDR, 32'hffffffff);
		reg_read(BAD_ADDR, 32'h0);
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h2f));
		$display("test reset values done");
		// Equal skew passes, one above fails
		skew_chk(6'h2f, 1'b0);
		skew_chk(6'h30, 1'b1);
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h2f) | ALIGN_B);
		$display("test default skew done");
		// Lowest limit, then out of range writes that must not land
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01));
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01) | ALIGN_B);
		skew_chk(6'h01, 1'b0);
		skew_chk(6'h02, 1'b1);
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h00));
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h30));
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01) | ALIGN_B);
		skew_chk(6'h01, 1'b0);
		$display("test skew limit done");
		// Restart the window; bad headers on empty cycles do not count
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b0, 6'h01));
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01));
		i_link_partner_model.send_gaps(100);
		// One short of the threshold, then the threshold
		i_link_partner_model.send_errors(96);
		check(32'(flag), 32'h0, "flag early");
		i_link_partner_model.send_errors(1);
		@(posedge clk) #1;
		check(32'(flag), 32'h1, "flag raise");
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01) | FLAG_B);
		// Past the first window end, which still held the threshold
		repeat (4000) @(posedge clk);
		#1 check(32'(flag), 32'h1, "flag hold");
		for (int i = 0; i < 7000 && flag !== 1'b0; i++) @(posedge clk) #1;
		check(32'(flag), 32'h0, "flag drop");
		$display("test error rate done");
		// Disabling clears the flag and stops counting
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h01));
		i_link_partner_model.send_errors(97);
		@(posedge clk) #1;
		check(32'(flag), 32'h1, "flag again");
		reg_write(RX_LANE_CONFIG_ADDR, cfg(1'b0, 6'h01));
		@(posedge clk) #1;
		check(32'(flag), 32'h0, "flag clear");
		i_link_partner_model.send_errors(120);
		@(posedge clk) #1;
		check(32'(flag), 32'h0, "flag off");
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b0, 6'h01));
		$display("test monitor off done");
		// A second reset brings back the build values
		@(posedge clk) #1 rst_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		reg_read(RX_LANE_CONFIG_ADDR, cfg(1'b1, 6'h2f));
		$display("test second reset done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
